// ===== rtl/brs_pkg.sv
// package of constants for the bridge reset sequencer
`default_nettype none
package brs_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned BUS_RESET_MS = 1;
  localparam int unsigned BUS_RESET_CYC = BUS_RESET_MS * 1000 * CLK_MHZ;
  localparam int unsigned INT_RESET_CYC = 16;
  localparam int unsigned CNT_W = 20;
  typedef enum logic [2:0] {
    BRS_COLD, BRS_HOT, BRS_INTRST, BRS_DELAY, BRS_RUN, BRS_SWRST
  } brs_state_t;
  typedef enum logic [1:0] {
    BRS_LVL_NONE, BRS_LVL_0, BRS_LVL_1, BRS_LVL_2
  } brs_level_t;
endpackage
`default_nettype wire

// ===== rtl/brs_sequencer.sv
// reset sequencer: reset levels, bus reset, eeprom load and retry gating
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - level 0 resets all, sticky too, loads eeprom
// - level 0 bus reset releases 1 ms later
// - hot reset or link loss: reload, keep sticky
// - level 1 bus reset releases 1 ms after
// - level 2 holds bus reset max(1 ms, bit)
// - level 2 drains traffic, drops requests, remodes only when clock_master
// - config requests retried until eeprom loaded
// - pending downstream requests discarded, ur answered
module brs_sequencer #(
  parameter int unsigned BUS_RESET_CYCLES = brs_pkg::BUS_RESET_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic upstream_reset_in_n,
  input wire logic hot_reset_msg,
  input wire logic link_layer_lost,
  input wire logic bus_reset_ctl,
  input wire logic eeprom_load_done,
  input wire logic cfg_req,
  input wire logic clock_master,
  output logic downstream_bus_reset_out_n,
  output logic reset_all_regs,
  output logic reset_nonsticky_regs,
  output logic eeprom_load_start,
  output logic cfg_retry,
  output logic drain_traffic,
  output logic downstream_flush_ur,
  output logic bus_mode_redetect,
  output brs_pkg::brs_level_t reset_level
);
  import brs_pkg::*;

  typedef struct packed {
    logic [1:0] sync_rst;
    logic [1:0] sync_hot;
    logic [1:0] sync_lost;
    brs_state_t st;
    brs_level_t lvl;
    logic [CNT_W-1:0] cnt;
    logic bus_rst;
    logic all_rst;
    logic ns_rst;
    logic load_go;
    logic loading;
    logic retry;
    logic drain;
    logic ur;
    logic remode;
  } brs_reg_t;

  brs_reg_t q;
  brs_reg_t next_q;
  logic in_rst_n;
  logic hot_evt;
  logic [CNT_W-1:0] bus_last;

  assign in_rst_n = q.sync_rst[1];
  assign hot_evt = q.sync_hot[1] | q.sync_lost[1];
  assign bus_last = CNT_W'(BUS_RESET_CYCLES - 1);

  always_comb begin
    next_q = q;
    // pins pass two flops; first stage feeds only the second
    next_q.sync_rst = {q.sync_rst[0], upstream_reset_in_n};
    next_q.sync_hot = {q.sync_hot[0], hot_reset_msg};
    next_q.sync_lost = {q.sync_lost[0], link_layer_lost};
    next_q.load_go = 1'b0;
    next_q.ur = 1'b0;
    if (q.loading && eeprom_load_done) begin
      next_q.loading = 1'b0;
      next_q.retry = 1'b0;
    end
    if (!in_rst_n) begin
      next_q.st = BRS_COLD;
      next_q.lvl = BRS_LVL_0;
      next_q.bus_rst = 1'b1;
      next_q.all_rst = 1'b1;
      next_q.ns_rst = 1'b1;
      next_q.cnt = '0;
      next_q.retry = 1'b1;
      next_q.loading = 1'b0;
      next_q.drain = 1'b0;
      next_q.remode = 1'b0;
    end else begin
      case (q.st)
        BRS_COLD: begin
          // input just released: load and start the 1 ms release timer
          next_q.all_rst = 1'b0;
          next_q.ns_rst = 1'b0;
          next_q.load_go = 1'b1;
          next_q.loading = 1'b1;
          next_q.cnt = '0;
          next_q.st = BRS_DELAY;
        end
        BRS_HOT: begin
          next_q.ns_rst = 1'b1;
          next_q.bus_rst = 1'b1;
          next_q.retry = 1'b1;
          next_q.cnt = '0;
          next_q.st = BRS_INTRST;
        end
        BRS_INTRST: begin
          // internal reset lasts a fixed count before the bus timer
          next_q.cnt = q.cnt + 1'b1;
          if (q.cnt == CNT_W'(INT_RESET_CYC - 1)) begin
            next_q.ns_rst = 1'b0;
            next_q.load_go = 1'b1;
            next_q.loading = 1'b1;
            next_q.cnt = '0;
            next_q.st = BRS_DELAY;
          end
        end
        BRS_DELAY: begin
          next_q.cnt = q.cnt + 1'b1;
          if (hot_evt) begin
            // restart counts as level 1 even mid level 0 release
            next_q.lvl = BRS_LVL_1;
            next_q.st = BRS_HOT;
          end else if (q.cnt == bus_last) begin
            next_q.bus_rst = 1'b0;
            next_q.lvl = BRS_LVL_NONE;
            next_q.st = BRS_RUN;
          end
        end
        BRS_RUN: begin
          if (hot_evt) begin
            next_q.lvl = BRS_LVL_1;
            next_q.st = BRS_HOT;
          end else if (bus_reset_ctl) begin
            next_q.lvl = BRS_LVL_2;
            next_q.bus_rst = 1'b1;
            next_q.drain = 1'b1;
            next_q.ur = 1'b1;
            next_q.remode = clock_master;
            next_q.cnt = '0;
            next_q.st = BRS_SWRST;
          end
        end
        BRS_SWRST: begin
          // no eeprom load and no register init at this level
          if (q.cnt != bus_last) begin
            next_q.cnt = q.cnt + 1'b1;
          end
          if (hot_evt) begin
            next_q.drain = 1'b0;
            next_q.remode = 1'b0;
            next_q.lvl = BRS_LVL_1;
            next_q.st = BRS_HOT;
          end else if (q.cnt == bus_last && !bus_reset_ctl) begin
            next_q.bus_rst = 1'b0;
            next_q.drain = 1'b0;
            next_q.remode = 1'b0;
            next_q.lvl = BRS_LVL_NONE;
            next_q.st = BRS_RUN;
          end
        end
        default: begin
          next_q.st = BRS_COLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{sync_rst: 2'b00, sync_hot: 2'b00, sync_lost: 2'b00,
             st: BRS_COLD, lvl: BRS_LVL_0, cnt: '0, bus_rst: 1'b1,
             all_rst: 1'b1, ns_rst: 1'b1, load_go: 1'b0, loading: 1'b0,
             retry: 1'b1, drain: 1'b0, ur: 1'b0, remode: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign downstream_bus_reset_out_n = ~q.bus_rst;
  assign reset_all_regs = q.all_rst;
  assign reset_nonsticky_regs = q.ns_rst;
  assign eeprom_load_start = q.load_go;
  assign cfg_retry = q.retry & cfg_req;
  assign drain_traffic = q.drain;
  assign downstream_flush_ur = q.ur;
  assign bus_mode_redetect = q.remode;
  assign reset_level = q.lvl;

  // hot entry: seen in run, register reset one cycle after the hot state
  sequence s_hot_start;
    q.st == BRS_RUN && in_rst_n && hot_evt;
  endsequence
  sequence s_hot_regs;
    reset_nonsticky_regs && !reset_all_regs;
  endsequence

  a_bus_low_input: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !in_rst_n |=> !downstream_bus_reset_out_n)
    else $error("bus reset released while input low");
  a_cold_load_pulse: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (q.st == BRS_COLD && in_rst_n) |=> eeprom_load_start)
    else $error("no eeprom load after level 0");
  a_cold_all_rst: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !in_rst_n |=> reset_all_regs)
    else $error("full register reset missing");
  a_release_timer: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(downstream_bus_reset_out_n) |-> $past(q.cnt) == bus_last)
    else $error("bus reset released before timer");
  a_hot_entry: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_hot_start |=> ##1 s_hot_regs)
    else $error("hot reset did not keep sticky");
  a_hot_level: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (in_rst_n && hot_evt && (q.st == BRS_RUN || q.st == BRS_DELAY ||
      q.st == BRS_SWRST)) |=> reset_level == BRS_LVL_1)
    else $error("hot event did not start level 1");
  a_hot_bus_rst: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (q.st == BRS_INTRST) |-> !downstream_bus_reset_out_n)
    else $error("bus reset not held in hot reset");
  a_sw_no_load: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (q.st == BRS_SWRST) |-> (!eeprom_load_start && !reset_nonsticky_regs))
    else $error("level 2 touched eeprom or registers");
  a_sw_bit_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (q.st == BRS_SWRST && bus_reset_ctl && in_rst_n && !hot_evt) |=>
      !downstream_bus_reset_out_n)
    else $error("bus reset dropped while bit set");
  a_sw_drain: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (q.st == BRS_SWRST) |-> drain_traffic)
    else $error("no drain in level 2");
  a_retry_load: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (q.loading && cfg_req) |-> cfg_retry)
    else $error("config request not retried during load");
  a_flush_ur: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (q.st == BRS_RUN && in_rst_n && !hot_evt && bus_reset_ctl) |=>
      downstream_flush_ur)
    else $error("pending requests not flushed");
endmodule // brs_sequencer
`default_nettype wire

// ===== verif/brs_host_model.sv
// far-side model: reset controller and root complex events
`timescale 1ns/1ps
`default_nettype none
module brs_host_model (
  input wire logic clk_sys,
  output logic upstream_reset_in_n,
  output logic hot_reset_msg,
  output logic link_layer_lost
);
  // starts low: held from clock valid until the first release
  initial begin
    upstream_reset_in_n = 1'b0;
    hot_reset_msg = 1'b0;
    link_layer_lost = 1'b0;
  end
  // low for n cycles; callers set n to ten times the scaled 1 ms
  task automatic pulse_reset(input int n);
    @(posedge clk_sys) #1 upstream_reset_in_n = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1 upstream_reset_in_n = 1'b1;
  endtask
  // 4 cycles so the two-flop synchroniser sees it
  task automatic hot(input bit link);
    @(posedge clk_sys) #1;
    if (link) link_layer_lost = 1'b1;
    else hot_reset_msg = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 {hot_reset_msg, link_layer_lost} = 2'b00;
  endtask
endmodule // brs_host_model
`default_nettype wire

// ===== verif/test_bridge_reset_sequencer.sv
// testbench for the bridge reset sequencer
`timescale 1ns/1ps
`default_nettype none
module test_bridge_reset_sequencer;
  import brs_pkg::*;
  localparam int N = 20;
  logic clk_sys, rst_n, up_n, hot, lost, ctl, done, req, cm;
  logic bus_n, all_r, nons, ld, retry, drain, ur, redet;
  brs_level_t lvl;
  int errors = 0;
  int cmp_count = 0;
  brs_host_model brs_host_model_i (.clk_sys(clk_sys),
    .upstream_reset_in_n(up_n), .hot_reset_msg(hot), .link_layer_lost(lost));
  brs_sequencer #(.BUS_RESET_CYCLES(N)) brs_sequencer_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .upstream_reset_in_n(up_n), .hot_reset_msg(hot),
    .link_layer_lost(lost), .bus_reset_ctl(ctl), .eeprom_load_done(done),
    .cfg_req(req), .clock_master(cm), .downstream_bus_reset_out_n(bus_n),
    .reset_all_regs(all_r), .reset_nonsticky_regs(nons),
    .eeprom_load_start(ld), .cfg_retry(retry), .drain_traffic(drain),
    .downstream_flush_ur(ur), .bus_mode_redetect(redet), .reset_level(lvl));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return bus_n;
      1: return ld;
      2: return nons;
      default: return drain;
    endcase
  endfunction
  task automatic wt(input int s, output int n);
    n = 0;
    while (pick(s) !== 1'b1 && n < 4 * N + 99) begin
      @(posedge clk_sys) #1;
      n++;
    end
    if (pick(s) !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask
  task automatic eeprom_done();
    chk(1, retry);
    done = 1'b1;
    @(posedge clk_sys) #1 done = 1'b0;
    @(posedge clk_sys) #1 chk(0, retry);
  endtask
  task automatic t_cold();
    int a, b;
    chk(1, all_r);
    chk(8'(BRS_LVL_0), 8'(lvl));
    fork
      brs_host_model_i.pulse_reset(10 * N);
      repeat (10 * N) @(posedge clk_sys) #1 chk(0, bus_n);
    join
    wt(1, a);
    wt(0, b);
    chk(1, b == N);
    eeprom_done();
    $display("cold reset done");
  endtask
  task automatic t_hot(input bit link);
    int a, b;
    brs_host_model_i.hot(link);
    wt(2, a);
    chk(0, all_r);
    chk(8'(BRS_LVL_1), 8'(lvl));
    wt(1, a);
    wt(0, b);
    chk(1, a + b == N + INT_RESET_CYC);
    eeprom_done();
    $display("hot reset done");
  endtask
  task automatic t_hot_sw();
    int a, b;
    ctl = 1'b1;
    wt(3, a);
    brs_host_model_i.hot(1'b0);
    ctl = 1'b0;
    wt(2, a);
    chk(8'(BRS_LVL_1), 8'(lvl));
    chk(0, all_r);
    chk(0, drain);
    chk(0, bus_n);
    wt(1, a);
    wt(0, b);
    chk(1, a + b == N + INT_RESET_CYC);
    eeprom_done();
    $display("hot reset inside bus reset done");
  endtask
  task automatic t_sw(input int hold, input logic m);
    int a, e;
    cm = m;
    ctl = 1'b1;
    wt(3, a);
    chk(1, ur);
    chk(m, redet);
    chk(8'(BRS_LVL_2), 8'(lvl));
    repeat (hold) @(posedge clk_sys) #1 chk(0, bus_n | ld);
    ctl = 1'b0;
    wt(0, a);
    // a late clear still costs the one edge that samples it
    e = hold < N ? N - hold : 1;
    chk(1, a == e);
    chk(0, drain);
    $display("bus reset hold %0d done", hold);
  endtask
  initial begin
    {rst_n, ctl, done, req, cm} = 5'b00010;
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_cold();
    t_hot(1'b0);
    t_hot(1'b1);
    t_sw(2, 1'b1);
    t_sw(2 * N, 1'b0);
    t_hot_sw();
    conclude();
  end
endmodule // test_bridge_reset_sequencer
`default_nettype wire
